// file: rtl/si_pkg.sv
// constants and types shared by the serial cpu port and its link-side slave
// assumes a 100 MHz core clock and a link clock made by the external master
package si_pkg;
	// =====================================================================
	// timing
	localparam int MCLK_PERIOD_NS     = 10;
	localparam int MST_SCLK_PERIOD_NS = 80;
	// half period of the driven serial clock, rounded down
	localparam int HALF_CYCLES        = MST_SCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
	localparam int SYNC_STAGES        = 3;
	// one extra cycle for the agreement flop
	localparam int STRAP_WAIT         = SYNC_STAGES + 1;

	// =====================================================================
	// slave frame: command byte, turnaround byte, data byte
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 8;
	localparam int CMD_BITS   = 8;
	localparam int TURN_BITS  = 8;
	localparam int FRAME_BITS = CMD_BITS + TURN_BITS + DATA_W;
	localparam int CMD_RW_POS = 7;
	localparam int CNT_W      = 5;

	// =====================================================================
	// master and boot engine
	localparam int XFER_W         = 32;
	localparam int LEN_W          = 6;
	localparam int STRAP_W        = 2;
	localparam int BOOT_HDR_BITS  = 32;
	localparam int BOOT_BYTE_BITS = 8;
	localparam logic [STRAP_W-1:0] STRAP_BOOT_SERIAL = 2'h1;
	localparam logic [7:0]         BOOT_READ_CMD     = 8'h03;
	localparam logic [23:0]        BOOT_START_ADDR   = 24'h000000;

	typedef enum logic [1:0] {ROLE_SLAVE, ROLE_MASTER, ROLE_BOOT} role_type;
	typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_HOLD} eng_state_type;
	typedef enum logic [2:0] {BOOT_STRAP, BOOT_CMD, BOOT_DATA, BOOT_END, BOOT_OFF} boot_state_type;
endpackage

// file: rtl/si_link_if.sv
// signals between the core-clock logic and the link-clock slave shifter
// cmd and wdata are held stable while their toggles cross
`timescale 1ns/10ps
interface si_link_if import si_pkg::*; ();
	logic [CMD_BITS-1:0] cmd;
	logic [DATA_W-1:0]   wdata;
	logic                req_tgl;
	logic                wr_tgl;
	logic [DATA_W-1:0]   rd_data;
	logic                link_rst;
	logic                dout;
	logic                dout_oe;

	modport link (output cmd, wdata, req_tgl, wr_tgl, dout, dout_oe, input rd_data, link_rst);
	modport core (input cmd, wdata, req_tgl, wr_tgl, dout, dout_oe, output rd_data, link_rst);
endinterface

// file: rtl/si_slave_link.sv
// slave-role shifter clocked by the external master's serial clock
// the clock may run while select is high; the bit count stays at zero
`timescale 1ns/10ps
module si_slave_link import si_pkg::*; (
	input  wire logic sclk_i,
	input  wire logic din_i,
	input  wire logic sel_n_i,
	si_link_if.link   lk
);
	logic [CNT_W-1:0]  bit_cnt;
	logic [DATA_W-2:0] in_sh;
	logic [DATA_W-1:0] out_sh;

	// =====================================================================
	// decode
	wire                    frame_rst  = sel_n_i | lk.link_rst;
	wire [DATA_W-1:0]       next_byte  = {in_sh, din_i};
	wire                    cmd_last   = (bit_cnt == CNT_W'(CMD_BITS - 1));
	wire                    turn_last  = (bit_cnt == CNT_W'(CMD_BITS + TURN_BITS - 1));
	wire                    data_last  = (bit_cnt == CNT_W'(FRAME_BITS - 1));
	wire                    frame_full = (bit_cnt == CNT_W'(FRAME_BITS));
	wire                    is_write   = lk.cmd[CMD_RW_POS];
	wire [CNT_W-1:0]        next_cnt   = frame_full ? bit_cnt : bit_cnt + 1'b1;

	// frame state ends with the select, not with a clock edge
	// select gates the port
	always_ff @(posedge sclk_i or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt    <= '0;
			lk.dout_oe <= 1'b0;
		end else begin
			bit_cnt    <= next_cnt;
			lk.dout_oe <= 1'b1;
		end
	end

	// toggles survive the frame so the core sees every one
	// request crossing
	always_ff @(posedge sclk_i or posedge lk.link_rst) begin
		if (lk.link_rst) begin
			lk.req_tgl <= 1'b0;
			lk.wr_tgl  <= 1'b0;
		end else begin
			if (cmd_last)
				lk.req_tgl <= ~lk.req_tgl;
			if (data_last && is_write)
				lk.wr_tgl <= ~lk.wr_tgl;
		end
	end

	// shift command and data in, read data out msb first
	always_ff @(posedge sclk_i) begin
		in_sh <= next_byte[DATA_W-2:0];
		if (cmd_last)
			lk.cmd <= next_byte;
		if (data_last)
			lk.wdata <= next_byte;
		if (turn_last)
			out_sh <= is_write ? '0 : lk.rd_data;
		else if (bit_cnt == '0)
			out_sh <= '0;
		else
			out_sh <= {out_sh[DATA_W-2:0], 1'b0};
	end

	assign lk.dout = out_sh[DATA_W-1];

	// =====================================================================
	// checks on the link clock
	chk_cmd_toggle: assert property (@(posedge sclk_i) disable iff (frame_rst)
		cmd_last |=> lk.req_tgl != $past(lk.req_tgl))
		else $error("command byte did not raise a request");
	chk_write_toggle: assert property (@(posedge sclk_i) disable iff (frame_rst)
		(data_last && is_write) |=> lk.wr_tgl != $past(lk.wr_tgl))
		else $error("write frame did not raise a write");
	chk_read_msb: assert property (@(posedge sclk_i) disable iff (frame_rst)
		(turn_last && !is_write) |=> lk.dout == $past(lk.rd_data[DATA_W-1]))
		else $error("read data msb not on data out");
	chk_oe_in_frame: assert property (@(posedge sclk_i) disable iff (frame_rst)
		(bit_cnt != '0) |-> lk.dout_oe)
		else $error("data out not driven inside frame");
	chk_clock_counts: assert property (@(posedge sclk_i) disable iff (frame_rst)
		cmd_last |=> bit_cnt == CNT_W'(CMD_BITS))
		else $error("bit count not advanced by link clock");
	cov_slave_read: cover property (@(posedge sclk_i) disable iff (frame_rst)
		turn_last && !is_write);
endmodule

// file: rtl/serial_cpu_port.sv
// serial cpu port: slave register access, programmable master, serial boot
// assumes reg_rdata_i is valid the cycle after reg_rd_o; straps steady at reset
`timescale 1ns/10ps
module serial_cpu_port import si_pkg::*; #(
	parameter int HALF       = HALF_CYCLES,
	parameter int BOOT_BYTES = 4096
) (
	input  wire logic                      mclk_i,
	input  wire logic                      sys_rst_i,
	input  wire logic                      sclk_i,
	output wire logic                      sclk_o,
	output wire logic                      sclk_oe_o,
	input  wire logic                      serial_port_data_in_i,
	output wire logic                      serial_data_out_o,
	output wire logic                      serial_data_out_oe_o,
	input  wire logic                      serial_port_select_n_i,
	output wire logic                      serial_port_select_n_o,
	output wire logic                      serial_port_select_n_oe_o,
	input  wire logic [STRAP_W-1:0]        boot_config_straps_i,
	input  wire logic                      role_master_i,
	output wire logic [ADDR_W-1:0]         reg_addr_o,
	output wire logic [DATA_W-1:0]         reg_wdata_o,
	output wire logic                      reg_wr_o,
	output wire logic                      reg_rd_o,
	input  wire logic [DATA_W-1:0]         reg_rdata_i,
	input  wire logic                      mst_start_i,
	input  wire logic [LEN_W-1:0]          mst_len_i,
	input  wire logic                      mst_cpol_i,
	input  wire logic                      mst_keep_sel_i,
	input  wire logic [XFER_W-1:0]         mst_wdata_i,
	output wire logic [XFER_W-1:0]         mst_rdata_o,
	output wire logic                      mst_done_o,
	output wire logic                      mst_busy_o,
	output wire logic [BOOT_BYTE_BITS-1:0] boot_data_o,
	output wire logic                      boot_valid_o,
	output wire logic                      boot_done_o
);
	localparam int HW  = $clog2(HALF + 1);
	localparam int BCW = $clog2(BOOT_BYTES + 1);

	si_link_if lk ();

	role_type                  role;
	eng_state_type             eng_state;
	boot_state_type            boot_state;
	logic [4:0]                s1;
	logic [4:0]                s2;
	logic [4:0]                s3;
	logic [4:0]                filt;
	logic [HW-1:0]             half_cnt;
	logic                      phase;
	logic                      sclk_drive;
	logic                      keep_q;
	logic                      eng_done;
	logic                      busy;
	logic                      mst_done;
	logic [LEN_W-1:0]          bits_left;
	logic [XFER_W-1:0]         tx_sh;
	logic [XFER_W-1:0]         rx_sh;
	logic                      sel_n;
	logic                      pins_oe;
	logic [2:0]                strap_wait;
	logic [BCW-1:0]            byte_cnt;
	logic [BOOT_BYTE_BITS-1:0] boot_data;
	logic                      boot_valid;
	logic                      boot_done;
	logic [ADDR_W-1:0]         reg_addr;
	logic [DATA_W-1:0]         reg_wdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic                      rd_pend;

	// =====================================================================
	// link-side slave
	si_slave_link u_link (
		.sclk_i  (sclk_i),
		.din_i   (serial_port_data_in_i),
		.sel_n_i (serial_port_select_n_i),
		.lk      (lk.link)
	);

	// =====================================================================
	// input synchronisers: data in, both toggles, straps
	wire [4:0] raw_in    = {boot_config_straps_i, lk.wr_tgl, lk.req_tgl, serial_port_data_in_i};
	wire [4:0] agree     = ~(s2 ^ s3);
	wire [4:0] next_filt = (agree & s3) | (~agree & filt);
	wire [4:0] changed   = next_filt ^ filt;
	wire       din_f     = filt[0];
	wire       req_edge  = changed[1];
	wire       wr_edge   = changed[2];
	wire       strap_boot = (filt[4:3] == STRAP_BOOT_SERIAL);

	// a change counts only once the second and third stages agree
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			filt <= '0;
		end else begin
			s1   <= raw_in;
			s2   <= s1;
			s3   <= s2;
			filt <= next_filt;
		end
	end

	// =====================================================================
	// role and engine request selection
	wire boot_active = (boot_state == BOOT_CMD) || (boot_state == BOOT_DATA)
		|| (boot_state == BOOT_END);
	wire is_slave    = (role == ROLE_SLAVE);
	wire eng_idle    = (eng_state == ENG_IDLE);
	wire half_zero   = (half_cnt == '0);
	wire trail_edge  = (eng_state == ENG_SHIFT) && half_zero && phase;
	wire hold_end    = (eng_state == ENG_HOLD) && half_zero;
	wire boot_go     = eng_idle && !eng_done && (role == ROLE_BOOT) // slave branch holds select
		&& ((boot_state == BOOT_CMD) || (boot_state == BOOT_DATA));
	// a zero length request is ignored rather than run as 64 bits
	wire mst_go      = mst_start_i && eng_idle && (role == ROLE_MASTER) && (mst_len_i != '0);
	wire eng_go      = boot_go | mst_go;
	wire boot_hdr    = (boot_state == BOOT_CMD);
	// programmable length, polarity and select hold
	wire [LEN_W-1:0]  eng_len  = boot_active ? (boot_hdr ? LEN_W'(BOOT_HDR_BITS)
		: LEN_W'(BOOT_BYTE_BITS)) : mst_len_i;
	// boot header is read command then start address
	wire [XFER_W-1:0] eng_tx   = boot_active ? (boot_hdr ? {BOOT_READ_CMD, BOOT_START_ADDR}
		: '0) : mst_wdata_i;
	wire              eng_cpol = boot_active ? 1'b0 : mst_cpol_i;
	wire              eng_keep = boot_active | mst_keep_sel_i;
	wire role_type    next_role = boot_active ? ROLE_BOOT
		: (role_master_i ? ROLE_MASTER : ROLE_SLAVE);

	// link logic is held quiet whenever the pins are ours
	// clock pin driven only outside slave role
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			role        <= ROLE_SLAVE;
			pins_oe     <= 1'b0;
			lk.link_rst <= 1'b1;
		end else begin
			role        <= next_role;
			pins_oe     <= (next_role != ROLE_SLAVE);
			lk.link_rst <= (next_role != ROLE_SLAVE);
		end
	end

	// =====================================================================
	// shift engine state: clock toggles every HALF cycles
	// driven serial clock
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			eng_state  <= ENG_IDLE;
			half_cnt   <= '0;
			phase      <= 1'b0;
			sclk_drive <= 1'b0;
			keep_q     <= 1'b0;
			eng_done   <= 1'b0;
			busy       <= 1'b0;
			mst_done   <= 1'b0;
		end else begin
			eng_done <= 1'b0;
			mst_done <= 1'b0;
			unique case (eng_state)
				ENG_IDLE: if (eng_go) begin
					eng_state  <= ENG_SHIFT;
					half_cnt   <= HW'(HALF - 1);
					phase      <= 1'b0;
					sclk_drive <= eng_cpol;
					keep_q     <= eng_keep;
					busy       <= 1'b1;
				end
				ENG_SHIFT: if (half_zero) begin
					half_cnt   <= HW'(HALF - 1);
					phase      <= ~phase;
					sclk_drive <= ~sclk_drive;
					if (phase && (bits_left == LEN_W'(1)))
						eng_state <= ENG_HOLD;
				end else begin
					half_cnt <= half_cnt - 1'b1;
				end
				// select is held one half period past the last edge
				ENG_HOLD: if (half_zero) begin
					eng_state <= ENG_IDLE;
					eng_done  <= 1'b1;
					busy      <= 1'b0;
					mst_done  <= (role == ROLE_MASTER);
				end else begin
					half_cnt <= half_cnt - 1'b1;
				end
			endcase
		end
	end

	// data moves on the trailing edge, sampled input is the filtered copy
	// take serial data in
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			tx_sh     <= '0;
			rx_sh     <= '0;
			bits_left <= '0;
		end else if (eng_go) begin
			tx_sh     <= eng_tx;
			bits_left <= eng_len;
		end else if (trail_edge) begin
			tx_sh     <= {tx_sh[XFER_W-2:0], 1'b0};
			rx_sh     <= {rx_sh[XFER_W-2:0], din_f};
			bits_left <= bits_left - 1'b1;
		end
	end

	// select low for the whole access
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			sel_n <= 1'b1;
		else if (is_slave || boot_state == BOOT_END)
			sel_n <= 1'b1;
		else if (eng_go)
			sel_n <= 1'b0;
		else if (hold_end && !keep_q)
			sel_n <= 1'b1;
	end

	// =====================================================================
	// boot sequencer
	// straps decide once after reset
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			boot_state <= BOOT_STRAP;
			strap_wait <= '0;
			byte_cnt   <= '0;
			boot_data  <= '0;
			boot_valid <= 1'b0;
			boot_done  <= 1'b0;
		end else begin
			boot_valid <= 1'b0;
			unique case (boot_state)
				BOOT_STRAP: if (strap_wait == 3'(STRAP_WAIT))
					boot_state <= strap_boot ? BOOT_CMD : BOOT_OFF;
				else
					strap_wait <= strap_wait + 1'b1;
				BOOT_CMD: if (eng_done)
					boot_state <= BOOT_DATA;
				// each byte handed on as it lands
				BOOT_DATA: if (eng_done) begin
					boot_valid <= 1'b1;
					boot_data  <= rx_sh[BOOT_BYTE_BITS-1:0];
					byte_cnt   <= byte_cnt + 1'b1;
					if (byte_cnt == BCW'(BOOT_BYTES - 1))
						boot_state <= BOOT_END;
				end
				BOOT_END: begin
					boot_done  <= 1'b1;
					boot_state <= BOOT_OFF;
				end
				BOOT_OFF: ;
			endcase
		end
	end

	// =====================================================================
	// slave register access on the core clock
	// rd_data is stable long before the turnaround byte ends
	// register read and write
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			reg_addr   <= '0;
			reg_wdata  <= '0;
			reg_wr     <= 1'b0;
			reg_rd     <= 1'b0;
			rd_pend    <= 1'b0;
			lk.rd_data <= '0;
		end else begin
			reg_wr  <= wr_edge && is_slave;
			reg_rd  <= req_edge && is_slave && !lk.cmd[CMD_RW_POS];
			rd_pend <= reg_rd;
			if ((req_edge || wr_edge) && is_slave)
				reg_addr <= lk.cmd[ADDR_W-1:0];
			if (wr_edge && is_slave)
				reg_wdata <= lk.wdata;
			if (rd_pend)
				lk.rd_data <= reg_rdata_i;
		end
	end

	// =====================================================================
	// pins and outputs
	// slave data out follows select
	assign serial_data_out_o         = is_slave ? lk.dout : tx_sh[XFER_W-1];
	assign serial_data_out_oe_o      = is_slave ? lk.dout_oe : pins_oe;
	assign sclk_o                    = sclk_drive;
	assign sclk_oe_o                 = pins_oe;
	assign serial_port_select_n_o    = sel_n;
	assign serial_port_select_n_oe_o = pins_oe;
	assign reg_addr_o                = reg_addr;
	assign reg_wdata_o               = reg_wdata;
	assign reg_wr_o                  = reg_wr;
	assign reg_rd_o                  = reg_rd;
	assign mst_rdata_o               = rx_sh;
	assign mst_done_o                = mst_done;
	assign mst_busy_o                = busy;
	assign boot_data_o               = boot_data;
	assign boot_valid_o              = boot_valid;
	assign boot_done_o               = boot_done;

	// =====================================================================
	// checks on the core clock
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	chk_slave_quiet: assert property (
		(is_slave && $past(is_slave)) |-> (!sclk_oe_o && !serial_port_select_n_oe_o))
		else $error("slave role drives clock or select");
	chk_sel_in_xfer: assert property (
		(eng_state != ENG_IDLE) |-> (!serial_port_select_n_o && serial_port_select_n_oe_o))
		else $error("select high during transfer");
	chk_sclk_half: assert property (
		(eng_state == ENG_SHIFT && $changed(sclk_o)) |-> ##1 $stable(sclk_o) [*3])
		else $error("serial clock half period too short");
	chk_mst_len: assert property (
		mst_go |=> (eng_state == ENG_SHIFT && bits_left == $past(mst_len_i)))
		else $error("master length not taken");
	chk_boot_hdr: assert property (
		(boot_go && boot_hdr) |=> (tx_sh[XFER_W-1 -: 8] == BOOT_READ_CMD && sclk_oe_o))
		else $error("boot header not loaded");
	chk_boot_byte: assert property (
		(eng_done && boot_state == BOOT_DATA)
			|=> (boot_valid_o && boot_data_o == $past(rx_sh[BOOT_BYTE_BITS-1:0])))
		else $error("boot byte not delivered");
	chk_boot_release: assert property (
		$rose(boot_done_o) |-> (serial_port_select_n_o && boot_state == BOOT_OFF))
		else $error("select not released after boot");
	chk_boot_strap: assert property (
		(boot_state == BOOT_STRAP && strap_wait == 3'(STRAP_WAIT))
			|=> ((boot_state == BOOT_CMD) == $past(strap_boot)))
		else $error("boot entry does not follow straps");
	chk_reg_write: assert property (
		(wr_edge && is_slave) |=> (reg_wr_o && reg_wdata_o == $past(lk.wdata)))
		else $error("slave write not issued");
	chk_reg_read: assert property (
		reg_rd_o |=> ##1 (lk.rd_data == $past(reg_rdata_i)))
		else $error("read data not captured");

	cov_boot_done: cover property ($rose(boot_done_o));
	cov_mst_xfer: cover property (mst_done_o);
	cov_slave_write: cover property (reg_wr_o);
	cov_slave_read: cover property (reg_rd_o);
endmodule

// file: sim/si_far_model.sv
// far-side model: serial memory in boot, serial peripheral in master role
// assumes the bench resolves the pin levels, pull-ups included
`timescale 1ns/10ps
module si_far_model (
	input  wire logic   clk_pin_i,
	input  wire logic   sel_n_i,
	input  wire logic   do_i,
	input  wire logic   cpol_i,
	output logic        din_o,
	output logic [31:0] rx_o,
	output logic [31:0] hdr_o
);
	int         cnt;
	logic [7:0] val;
	wire        lead = clk_pin_i ^ cpol_i;

	// ==================================================================
	// frame handling
	// released data line floats to its pull-up level
	initial din_o = 1'b1;
	always @(negedge sel_n_i) cnt = 0;
	always @(posedge sel_n_i) din_o = 1'b1;
	// reply byte per eight bits, launched on the same edge
	always @(posedge lead) begin
		if (!sel_n_i) begin
			rx_o = {rx_o[30:0], do_i};
			if (cnt == 31) hdr_o = rx_o;
			val = 8'hC0 + 8'(cnt / 8);
			din_o = val[7 - (cnt % 8)];
			cnt++;
		end
	end
endmodule

// file: sim/serial_cpu_port_slave_master_boot_tb.sv
// bench for the serial cpu port in slave, master and boot roles
// assumes si_far_model sits on the pins; bench plays the external master
`timescale 1ns/10ps
module serial_cpu_port_slave_master_boot_tb import si_pkg::*; ();
	localparam int H  = 8;
	localparam int NB = 4;
	typedef struct packed {logic [6:0] a; logic [7:0] d;} row_type;
	row_type rows [3] = '{'{7'h00, 8'h5A}, '{7'h7F, 8'hA5}, '{7'h2A, 8'hFF}};
	logic mclk = 0, rst = 1, tb_sclk = 0, tb_din = 1, tb_sel = 1, role = 0;
	logic start = 0, cpol = 0, keep = 0;
	logic [5:0]  len = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic [1:0]  straps = 2'h0;
	logic [7:0]  rdata = 8'h00;
	logic [7:0]  mem [128];
	logic [7:0]  rd;
	logic [7:0]  boot_q [$];
	int bad_count = 0, samples_checked = 0, wr_seen = 0, drive_bad = 0, n;
	wire sclk_o, sclk_oe, do_o, do_oe, sel_o, sel_oe, wr, rdp, done, busy, bvalid, bdone;
	wire mdl_din;
	wire [6:0]  addr;
	wire [7:0]  wd, bdata;
	wire [31:0] mrd, mrx, hdr;
	// shared pins resolved from the dut's output enables
	wire sclk_pin = sclk_oe ? sclk_o : tb_sclk;
	wire sel_pin  = sel_oe ? sel_o : tb_sel;
	wire din_pin  = sel_oe ? mdl_din : tb_din;
	wire do_pin   = do_oe ? do_o : 1'b1;

	always #5 mclk = ~mclk;

	serial_cpu_port #(.HALF(H), .BOOT_BYTES(NB)) u_dut (
		.mclk_i(mclk), .sys_rst_i(rst), .sclk_i(sclk_pin), .sclk_o(sclk_o),
		.sclk_oe_o(sclk_oe), .serial_port_data_in_i(din_pin), .serial_data_out_o(do_o),
		.serial_data_out_oe_o(do_oe), .serial_port_select_n_i(sel_pin),
		.serial_port_select_n_o(sel_o), .serial_port_select_n_oe_o(sel_oe),
		.boot_config_straps_i(straps), .role_master_i(role), .reg_addr_o(addr),
		.reg_wdata_o(wd), .reg_wr_o(wr), .reg_rd_o(rdp), .reg_rdata_i(rdata),
		.mst_start_i(start), .mst_len_i(len), .mst_cpol_i(cpol), .mst_keep_sel_i(keep),
		.mst_wdata_i(wdata), .mst_rdata_o(mrd), .mst_done_o(done), .mst_busy_o(busy),
		.boot_data_o(bdata), .boot_valid_o(bvalid), .boot_done_o(bdone));

	si_far_model u_far (.clk_pin_i(sclk_pin), .sel_n_i(sel_pin), .do_i(do_pin),
		.cpol_i(cpol), .din_o(mdl_din), .rx_o(mrx), .hdr_o(hdr));

	// ==================================================================
	// register file behind the port, and pin watch while the engine runs
	always @(posedge mclk) begin
		if (wr === 1'b1) begin
			mem[addr] <= wd;
			wr_seen <= wr_seen + 1;
		end
		if (rdp === 1'b1) rdata <= mem[addr];
		if (bvalid === 1'b1) boot_q.push_back(bdata);
		if (busy === 1'b1 && {sclk_oe, sel_oe, sel_o} !== 3'b110) drive_bad++;
	end

	// ==================================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task complete_run;
		$display("checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// slave frame, msb first; read bits taken on falling edges 16..23
	task automatic frame(input logic [23:0] bits, input int nb, output logic [7:0] r);
		#3.3 tb_sel = 0;
		for (int i = 0; i < nb; i++) begin
			tb_din = bits[23-i];
			#40 tb_sclk = 1;
			#40 tb_sclk = 0;
			if (i >= 15 && i <= 22) r = {r[6:0], do_pin};
		end
		#40 tb_sel = 1;
		tb_din = 1;
		tick(8);
	endtask

	// start held until the take edge, then a bounded wait for done
	task automatic xfer(input logic [5:0] l, input logic p, k, input logic [31:0] w);
		len = l;
		cpol = p;
		keep = k;
		wdata = w;
		start = 1;
		tick(1);
		start = 0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			tick(1);
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			complete_run();
		end
	endtask

	// ==================================================================
	// main sequence
	initial begin
		tick(16);
		rst = 0;
		tick(8);
		check({sclk_oe, sel_oe, do_oe, sel_o, bdone, busy}, 6'h04);
		for (int r = 0; r < 3; r++) begin
			frame({1'b1, rows[r].a, 8'h00, rows[r].d}, 24, rd);
			check(wr_seen, r + 1);
			frame({1'b0, rows[r].a, 16'h0000}, 24, rd);
			check(rd, rows[r].d);
			check(do_oe, 1'b0);
		end
		// aborted write, then clocks with select high
		frame({1'b1, 7'h11, 16'h00C3}, 20, rd);
		repeat (8) begin
			#40 tb_sclk = 1;
			#40 tb_sclk = 0;
		end
		tick(8);
		check(wr_seen, 3);
		check(do_oe, 1'b0);
		// master role, mode with idle-low clock, then idle-high with select kept
		role = 1;
		tick(2);
		xfer(6'd8, 1'b0, 1'b0, 32'h96000000);
		check(n, 8 * 2 * H + H);
		check(mrx[7:0], 8'h96);
		check(mrd[7:0], 8'hC0);
		tick(2);
		check({sclk_oe, sel_o}, 2'b11);
		len = 6'd0;
		start = 1;
		tick(3);
		start = 0;
		check(busy, 1'b0);
		xfer(6'd32, 1'b1, 1'b1, 32'h1234ABCD);
		check(n, 32 * 2 * H + H);
		check(mrx, 32'h1234ABCD);
		check(mrd, 32'hC0C1C2C3);
		tick(2);
		check(sel_o, 1'b0);
		// serial boot chosen by the straps
		rst = 1;
		straps = 2'h1;
		role = 0;
		cpol = 0;
		keep = 0;
		tick(4);
		rst = 0;
		n = 0;
		while (bdone !== 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		if (n >= 4000) bad_count++;
		check(hdr, {BOOT_READ_CMD, BOOT_START_ADDR});
		check(boot_q.size(), NB);
		for (int i = 0; i < NB; i++) check(boot_q[i], 8'hC4 + i);
		tick(2);
		check(sel_o, 1'b1);
		check(drive_bad, 0);
		complete_run();
	end
endmodule
